// ===== hw/cdr_core.sv
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
// Behaviour
// - a 16-bit program counter points at the instruction to fetch and run.
// - the 16-bit accumulator holds operands and results; byte ops use its low byte.
// - a 16-bit temporary accumulator is the second operand; byte ops use its low byte.
// - a 16-bit index register modifies operand addresses for indexed access.
// - a 16-bit extra pointer supplies a memory address for operands.
// - a 16-bit stack pointer marks the current place in the stack area.
// - status word is bank pointer in upper byte, condition codes in lower byte.
// - half-carry is set by carry or borrow between bit 3 and bit 4.
// - interrupt enable permits interrupts when set; reset clears it.
// - a request is served only if its level beats the allowed-level field.
// - negative flag copies the result's most significant bit.
// - zero flag is set exactly when the result is zero.
// - overflow flag is set on two's-complement overflow.
// - carry takes carry or borrow out of bit 7 (bit 15 for 16-bit ops), or the shifted-out bit.
// - 8-bit general registers sit in banks of eight, up to 32 banks.
// - 64 Kbyte space: I/O lowest, data above it, program at the top.
module cdr_core
    import cdr_pkg::*;
(
    // clock and reset
    input logic mclk_i,
    input logic reset_n_i,
    // register port
    input logic [3:0] reg_addr_i,
    input logic [15:0] reg_wdata_i,
    input logic reg_we_i,
    input logic reg_re_i,
    output logic [15:0] reg_rdata_o,
    // execution control
    input logic alu_go_i,
    input cdr_op_e alu_op_i,
    input logic pc_step_i,
    // interrupt gating
    input logic irq_req_i,
    input logic [1:0] irq_level_i,
    output logic irq_take_o,
    // general register and memory map lookup
    input logic [2:0] gpr_sel_i,
    output logic [15:0] gpr_addr_o,
    input logic [15:0] mem_addr_i,
    output logic [1:0] region_o,
    // register views
    output logic [15:0] pc_o,
    output logic [15:0] acc_o,
    output logic [15:0] tmp_o,
    output logic [15:0] ix_o,
    output logic [15:0] ep_o,
    output logic [15:0] sp_o,
    output logic [15:0] ps_o
);
    cdr_alu_if alu_bus ();

    logic [15:0] pc_q;
    logic [15:0] acc_q;
    logic [15:0] tmp_q;
    logic [15:0] ix_q;
    logic [15:0] ep_q;
    logic [15:0] sp_q;
    logic [7:0] bank_pointer_q;
    logic [1:0] allowed_level_q;
    logic h_q;
    logic i_q;
    logic n_q;
    logic z_q;
    logic v_q;
    logic c_q;
    logic [7:0] cond_code_byte;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic irq_take_q;
    logic irq_take_d;
    logic [15:0] gpr_addr_q;
    logic [1:0] region_q;
    logic [1:0] region_d;
    logic wr_pc;
    logic wr_acc;
    logic wr_tmp;
    logic wr_ix;
    logic wr_ep;
    logic wr_sp;
    logic wr_ps;

    assign alu_bus.op = alu_op_i;
    assign alu_bus.a = acc_q;
    assign alu_bus.t = tmp_q;

    cdr_alu u_alu (
        .bus (alu_bus.alu)
    );

    assign wr_pc = reg_we_i && (reg_addr_i == REG_PC);
    assign wr_acc = reg_we_i && (reg_addr_i == REG_ACC);
    assign wr_tmp = reg_we_i && (reg_addr_i == REG_TMP);
    assign wr_ix = reg_we_i && (reg_addr_i == REG_IX);
    assign wr_ep = reg_we_i && (reg_addr_i == REG_EP);
    assign wr_sp = reg_we_i && (reg_addr_i == REG_SP);
    assign wr_ps = reg_we_i && (reg_addr_i == REG_PS);

    assign cond_code_byte = {h_q, i_q, allowed_level_q, n_q, z_q, v_q, c_q};

    // program counter: a software load beats a step in the same cycle
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pc_q <= RST_WORD;
        end else if (wr_pc) begin
            pc_q <= reg_wdata_i;
        end else if (pc_step_i) begin
            pc_q <= pc_q + PC_STEP;
        end
    end

    // accumulator: the arithmetic result wins over a register write
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            acc_q <= RST_WORD;
        end else if (alu_go_i) begin
            acc_q <= alu_bus.res;
        end else if (wr_acc) begin
            acc_q <= reg_wdata_i;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tmp_q <= RST_WORD;
        end else if (wr_tmp) begin
            tmp_q <= reg_wdata_i;
        end
    end

    // pointer registers
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ix_q <= RST_WORD;
            ep_q <= RST_WORD;
            sp_q <= RST_WORD;
        end else begin
            if (wr_ix) begin
                ix_q <= reg_wdata_i;
            end
            if (wr_ep) begin
                ep_q <= reg_wdata_i;
            end
            if (wr_sp) begin
                sp_q <= reg_wdata_i;
            end
        end
    end

    // bank pointer, allowed level and enable are software-owned
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bank_pointer_q <= RST_BANK;
            allowed_level_q <= RST_LEVEL;
            i_q <= RST_FLAG;
        end else if (wr_ps) begin
            bank_pointer_q <= reg_wdata_i[15:8];
            allowed_level_q <= reg_wdata_i[CC_IL_HI:CC_IL_LO];
            i_q <= reg_wdata_i[CC_I];
        end
    end

    // result flags: hardware update beats a software write of the status word
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            h_q <= RST_FLAG;
            n_q <= RST_FLAG;
            z_q <= RST_FLAG;
            v_q <= RST_FLAG;
            c_q <= RST_FLAG;
        end else if (alu_go_i) begin
            n_q <= alu_bus.n;
            z_q <= alu_bus.z;
            c_q <= alu_bus.c;
            if (alu_bus.upd_hv) begin
                h_q <= alu_bus.h;
                v_q <= alu_bus.v;
            end
        end else if (wr_ps) begin
            h_q <= reg_wdata_i[CC_H];
            n_q <= reg_wdata_i[CC_N];
            z_q <= reg_wdata_i[CC_Z];
            v_q <= reg_wdata_i[CC_V];
            c_q <= reg_wdata_i[CC_C];
        end
    end

    // read mux; reads show the value before a same-cycle write
    always_comb begin
        rdata_d = 16'h0000;
        unique case (reg_addr_i)
            REG_PC: rdata_d = pc_q;
            REG_ACC: rdata_d = acc_q;
            REG_TMP: rdata_d = tmp_q;
            REG_IX: rdata_d = ix_q;
            REG_EP: rdata_d = ep_q;
            REG_SP: rdata_d = sp_q;
            REG_PS: rdata_d = {bank_pointer_q, cond_code_byte};
            default: rdata_d = 16'h0000;
        endcase
    end

    // read data stand for one cycle only, zero otherwise
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= RST_WORD;
        end else if (reg_re_i) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= RST_WORD;
        end
    end

    // lower level number is higher priority, so level 3 is never taken
    assign irq_take_d = irq_req_i && i_q && (irq_level_i < allowed_level_q);

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_take_q <= RST_FLAG;
        end else begin
            irq_take_q <= irq_take_d;
        end
    end

    // only five pointer bits reach the address: 32 banks of eight bytes
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gpr_addr_q <= GPR_BASE;
        end else begin
            gpr_addr_q <= GPR_BASE + {8'h00, bank_pointer_q[4:0], gpr_sel_i};
        end
    end

    always_comb begin
        if (mem_addr_i < IO_TOP) begin
            region_d = REGION_IO;
        end else if (mem_addr_i < PROG_BASE) begin
            region_d = REGION_DATA;
        end else begin
            region_d = REGION_PROG;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            region_q <= REGION_IO;
        end else begin
            region_q <= region_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign irq_take_o = irq_take_q;
    assign gpr_addr_o = gpr_addr_q;
    assign region_o = region_q;
    assign pc_o = pc_q;
    assign acc_o = acc_q;
    assign tmp_o = tmp_q;
    assign ix_o = ix_q;
    assign ep_o = ep_q;
    assign sp_o = sp_q;
    assign ps_o = {bank_pointer_q, cond_code_byte};

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);

    AST_PC_STEP: assert property (
        pc_step_i && !wr_pc |=> pc_o == $past(pc_o) + PC_STEP)
        else $error("program counter did not step by one");

    AST_PC_LOAD: assert property (
        wr_pc |=> pc_o == $past(reg_wdata_i))
        else $error("program counter load lost");

    AST_BYTE_HIGH_KEEP: assert property (
        alu_go_i && (alu_op_i inside {OP_ADD8, OP_SUB8, OP_SHL8, OP_SHR8})
        |=> acc_o[15:8] == $past(acc_o[15:8]))
        else $error("byte operation touched upper accumulator byte");

    AST_ADD8_SUM: assert property (
        alu_go_i && alu_op_i == OP_ADD8
        |=> acc_o[7:0] == 8'($past(acc_o[7:0]) + $past(tmp_o[7:0])))
        else $error("byte add result wrong");

    AST_READ_LATENCY: assert property (
        reg_re_i && reg_addr_i == REG_PS |=> reg_rdata_o == $past(ps_o) ##1
        ($past(reg_re_i) || reg_rdata_o == 16'h0000))
        else $error("status read data wrong or held too long");

    AST_HALF_CARRY: assert property (
        alu_go_i && alu_op_i == OP_ADD16
        |=> ps_o[CC_H] == (5'({1'b0, $past(acc_o[3:0])} + {1'b0, $past(tmp_o[3:0])}) > 5'h0F))
        else $error("half carry wrong after add");

    // judged from the visible status word, so a misplaced field shows up
    AST_IRQ_GATE: assert property (
        irq_req_i && ps_o[CC_I] && irq_level_i < ps_o[CC_IL_HI:CC_IL_LO] |=> irq_take_o)
        else $error("allowed request not taken");

    AST_IRQ_BLOCK: assert property (
        !ps_o[CC_I] || irq_level_i >= ps_o[CC_IL_HI:CC_IL_LO] |=> !irq_take_o)
        else $error("interrupt taken while blocked");

    AST_IRQ_LOWEST: assert property (
        irq_level_i == 2'h3 |=> !irq_take_o)
        else $error("lowest level request taken");

    AST_IRQ_OFF: assert property (
        !i_q |=> !irq_take_o)
        else $error("interrupt taken with enable clear");

    AST_ZERO_NEG: assert property (
        alu_go_i && alu_op_i inside {OP_ADD16, OP_SUB16}
        |=> ps_o[CC_Z] == (acc_o == 16'h0000) && ps_o[CC_N] == acc_o[15])
        else $error("zero or negative flag wrong");

    AST_SHIFT_CARRY: assert property (
        alu_go_i && alu_op_i == OP_SHR8 |=> ps_o[CC_C] == $past(acc_o[0]))
        else $error("shift right carry is not the bit shifted out");

    AST_GPR_ADDR: assert property (
        ##1 gpr_addr_o == GPR_BASE + {8'h00, $past(bank_pointer_q[4:0]), $past(gpr_sel_i)})
        else $error("general register address wrong");

    AST_REGION_MAP: assert property (
        mem_addr_i >= PROG_BASE |=> region_o == REGION_PROG)
        else $error("top of memory not mapped to program");

    AST_SUB8_DIFF: assert property (
        alu_go_i && alu_op_i == OP_SUB8
        |=> acc_o[7:0] == 8'($past(acc_o[7:0]) - $past(tmp_o[7:0])))
        else $error("byte subtract result wrong");

    AST_ADD8_CARRY: assert property (
        alu_go_i && alu_op_i == OP_ADD8
        |=> ps_o[CC_C] == ({1'b0, $past(acc_o[7:0])} + {1'b0, $past(tmp_o[7:0])} > 9'h0FF))
        else $error("byte add carry wrong");

    AST_SHL_CARRY: assert property (
        alu_go_i && alu_op_i == OP_SHL8 |=> ps_o[CC_C] == $past(acc_o[7]))
        else $error("shift left carry is not the bit shifted out");

    // byte ops judge zero on the low byte only
    AST_ZERO_BYTE: assert property (
        alu_go_i && (alu_op_i inside {OP_ADD8, OP_SUB8, OP_SHL8, OP_SHR8})
        |=> ps_o[CC_Z] == (acc_o[7:0] == 8'h00))
        else $error("zero flag wrong after byte operation");
endmodule

// ===== inc/cdr_pkg.sv
package cdr_pkg;
    // register slots on the plain register port
    localparam logic [3:0] REG_PC = 4'h0;
    localparam logic [3:0] REG_ACC = 4'h1;
    localparam logic [3:0] REG_TMP = 4'h2;
    localparam logic [3:0] REG_IX = 4'h3;
    localparam logic [3:0] REG_EP = 4'h4;
    localparam logic [3:0] REG_SP = 4'h5;
    localparam logic [3:0] REG_PS = 4'h6;
    // condition-code byte layout
    localparam int CC_C = 0;
    localparam int CC_V = 1;
    localparam int CC_Z = 2;
    localparam int CC_N = 3;
    localparam int CC_IL_LO = 4;
    localparam int CC_IL_HI = 5;
    localparam int CC_I = 6;
    localparam int CC_H = 7;
    // values after reset
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_BANK = 8'h00;
    localparam logic [1:0] RST_LEVEL = 2'h3;
    localparam logic RST_FLAG = 1'b0;
    // memory map
    localparam logic [15:0] IO_TOP = 16'h0080;
    localparam logic [15:0] PROG_BASE = 16'h8000;
    localparam logic [15:0] GPR_BASE = 16'h0100;
    localparam logic [1:0] REGION_IO = 2'h0;
    localparam logic [1:0] REGION_DATA = 2'h1;
    localparam logic [1:0] REGION_PROG = 2'h2;
    localparam logic [15:0] PC_STEP = 16'h0001;

    typedef enum logic [2:0] {
        OP_ADD8,
        OP_SUB8,
        OP_ADD16,
        OP_SUB16,
        OP_SHL8,
        OP_SHR8
    } cdr_op_e;
endpackage

// ===== inc/cdr_alu_if.sv
`timescale 1ns/1ps
interface cdr_alu_if;
    import cdr_pkg::*;
    cdr_op_e op;
    logic [15:0] a;
    logic [15:0] t;
    logic [15:0] res;
    logic h;
    logic n;
    logic z;
    logic v;
    logic c;
    logic upd_hv;
    modport core (output op, output a, output t,
                  input res, input h, input n, input z, input v, input c, input upd_hv);
    modport alu (input op, input a, input t,
                 output res, output h, output n, output z, output v, output c, output upd_hv);
endinterface

// ===== hw/cdr_alu.sv
`timescale 1ns/1ps
module cdr_alu
    import cdr_pkg::*;
(
    cdr_alu_if.alu bus
);
    logic [8:0] s9;
    logic [16:0] s17;
    logic [4:0] h5;
    logic sub;

    always_comb begin
        sub = (bus.op == OP_SUB8) || (bus.op == OP_SUB16);
        s9 = sub ? ({1'b0, bus.a[7:0]} - {1'b0, bus.t[7:0]})
                 : ({1'b0, bus.a[7:0]} + {1'b0, bus.t[7:0]});
        s17 = sub ? ({1'b0, bus.a} - {1'b0, bus.t}) : ({1'b0, bus.a} + {1'b0, bus.t});
        // borrow or carry across the nibble boundary
        h5 = sub ? ({1'b0, bus.a[3:0]} - {1'b0, bus.t[3:0]})
                 : ({1'b0, bus.a[3:0]} + {1'b0, bus.t[3:0]});
        bus.h = h5[4];
        bus.upd_hv = 1'b1;
        bus.res = bus.a;
        bus.c = 1'b0;
        bus.v = 1'b0;
        unique case (bus.op)
            OP_ADD8, OP_SUB8: begin
                // byte ops leave the upper byte alone
                bus.res = {bus.a[15:8], s9[7:0]};
                bus.c = s9[8];
                bus.v = sub ? ((bus.a[7] != bus.t[7]) && (s9[7] != bus.a[7]))
                            : ((bus.a[7] == bus.t[7]) && (s9[7] != bus.a[7]));
            end
            OP_ADD16, OP_SUB16: begin
                bus.res = s17[15:0];
                bus.c = s17[16];
                bus.v = sub ? ((bus.a[15] != bus.t[15]) && (s17[15] != bus.a[15]))
                            : ((bus.a[15] == bus.t[15]) && (s17[15] != bus.a[15]));
            end
            OP_SHL8: begin
                bus.res = {bus.a[15:8], bus.a[6:0], 1'b0};
                bus.c = bus.a[7];
                bus.upd_hv = 1'b0;
            end
            OP_SHR8: begin
                bus.res = {bus.a[15:8], 1'b0, bus.a[7:1]};
                bus.c = bus.a[0];
                bus.upd_hv = 1'b0;
            end
            default: begin
                bus.upd_hv = 1'b0;
            end
        endcase
        if ((bus.op == OP_ADD16) || (bus.op == OP_SUB16)) begin
            bus.n = bus.res[15];
            bus.z = (bus.res == 16'h0000);
        end else begin
            bus.n = bus.res[7];
            bus.z = (bus.res[7:0] == 8'h00);
        end
    end
endmodule

// ===== bench/cdr_testbench.sv
`timescale 1ns/1ps
module testbench
    import cdr_pkg::*;
;
    logic mclk_i;
    logic reset_n;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_we;
    logic reg_re;
    logic [15:0] reg_rdata;
    logic alu_go;
    cdr_op_e alu_op;
    logic pc_step;
    logic irq_req;
    logic [1:0] irq_level;
    logic irq_take;
    logic [2:0] gpr_sel;
    logic [15:0] gpr_addr;
    logic [15:0] mem_addr;
    logic [1:0] region;
    logic [15:0] pc, acc, tmp, ix, ep, sp, ps;
    logic [15:0] rv;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;

    cdr_core DUT (
        .mclk_i(mclk_i), .reset_n_i(reset_n),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we),
        .reg_re_i(reg_re), .reg_rdata_o(reg_rdata),
        .alu_go_i(alu_go), .alu_op_i(alu_op), .pc_step_i(pc_step),
        .irq_req_i(irq_req), .irq_level_i(irq_level), .irq_take_o(irq_take),
        .gpr_sel_i(gpr_sel), .gpr_addr_o(gpr_addr),
        .mem_addr_i(mem_addr), .region_o(region),
        .pc_o(pc), .acc_o(acc), .tmp_o(tmp), .ix_o(ix), .ep_o(ep), .sp_o(sp), .ps_o(ps)
    );

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task stop_test();
        $display("mismatches %0d of %0d compares", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // hang guard, well beyond the under two hundred cycles the scenarios take
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            stop_test();
        end
    end

    task check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] view(input int i);
        case (i)
            0: view = pc;
            1: view = acc;
            2: view = tmp;
            3: view = ix;
            4: view = ep;
            5: view = sp;
            default: view = ps;
        endcase
    endfunction

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk_i);
        reg_we <= 1'b0;
        #1;
    endtask

    task rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk_i);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge mclk_i);
        reg_re <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task t_reset_values();
        check(ps, 16'h0030);
        for (int i = 0; i < 6; i++) begin
            check(view(i), 16'h0000);
        end
        check(gpr_addr, 16'h0100);
        check({15'h0000, irq_take}, 16'h0000);
    endtask

    task t_regs();
        for (int i = 0; i < 7; i++) begin
            wr(i[3:0], 16'h5A30 ^ (16'h1111 * i[15:0]));
            check(view(i), 16'h5A30 ^ (16'h1111 * i[15:0]));
            rd(i[3:0], rv);
            check(rv, 16'h5A30 ^ (16'h1111 * i[15:0]));
        end
        // read data stands one cycle only
        @(posedge mclk_i);
        #1;
        check(reg_rdata, 16'h0000);
        rd(4'h7, rv);
        check(rv, 16'h0000);
        rd(4'hF, rv);
        check(rv, 16'h0000);
    endtask

    // flags: H 80, N 08, Z 04, V 02, C 01 in the low byte
    task alu_case(input cdr_op_e o, input logic [15:0] a, input logic [15:0] t,
                  input logic [15:0] p, input logic [15:0] ea, input logic [7:0] fe);
        wr(REG_ACC, a);
        wr(REG_TMP, t);
        wr(REG_PS, p);
        @(posedge mclk_i);
        alu_go <= 1'b1;
        alu_op <= o;
        @(posedge mclk_i);
        alu_go <= 1'b0;
        #1;
        check(acc, ea);
        check({8'h00, ps[7:0] & 8'h8F}, {8'h00, fe});
    endtask

    task t_alu();
        alu_case(OP_ADD8, 16'h12FF, 16'h0001, 16'h0030, 16'h1200, 8'h85);
        alu_case(OP_ADD8, 16'h007F, 16'h0001, 16'h0030, 16'h0080, 8'h8A);
        alu_case(OP_ADD8, 16'h0010, 16'h0020, 16'h0030, 16'h0030, 8'h00);
        alu_case(OP_SUB8, 16'h0000, 16'h0001, 16'h0030, 16'h00FF, 8'h89);
        alu_case(OP_SUB8, 16'h0080, 16'h0001, 16'h0030, 16'h007F, 8'h82);
        alu_case(OP_ADD16, 16'h7FFF, 16'h0001, 16'h0030, 16'h8000, 8'h8A);
        alu_case(OP_SUB16, 16'h0001, 16'h0001, 16'h0030, 16'h0000, 8'h04);
        // shifts keep H and V as they were
        alu_case(OP_SHL8, 16'h0081, 16'h0000, 16'h00B2, 16'h0002, 8'h83);
        alu_case(OP_SHR8, 16'h0001, 16'h0000, 16'h00B2, 16'h0000, 8'h87);
    endtask

    task irq_try(input logic [15:0] p, input logic [1:0] lvl, input logic exp);
        wr(REG_PS, p);
        @(posedge mclk_i);
        irq_req <= 1'b1;
        irq_level <= lvl;
        @(posedge mclk_i);
        #1;
        check({15'h0000, irq_take}, {15'h0000, exp});
        @(posedge mclk_i);
        irq_req <= 1'b0;
    endtask

    task t_irq();
        for (int l = 0; l < 4; l++) begin
            irq_try(16'h0060, l[1:0], l < 2);
        end
        irq_try(16'h0020, 2'h0, 1'b0);
        irq_try(16'h0040, 2'h0, 1'b0);
        irq_try(16'h0070, 2'h2, 1'b1);
        // a mid-run reset must drop the enable again
        wr(REG_PS, 16'h0060);
        @(posedge mclk_i);
        reset_n <= 1'b0;
        repeat (3) @(posedge mclk_i);
        reset_n <= 1'b1;
        #1;
        check(ps, 16'h0030);
    endtask

    task gpr_try(input logic [7:0] bank, input logic [2:0] sel, input logic [15:0] exp);
        wr(REG_PS, {bank, 8'h30});
        @(posedge mclk_i);
        gpr_sel <= sel;
        @(posedge mclk_i);
        #1;
        check(gpr_addr, exp);
    endtask

    task region_try(input logic [15:0] a, input logic [1:0] exp);
        @(posedge mclk_i);
        mem_addr <= a;
        @(posedge mclk_i);
        #1;
        check({14'h0000, region}, {14'h0000, exp});
    endtask

    task t_map();
        gpr_try(8'h03, 3'h5, 16'h011D);
        gpr_try(8'h1F, 3'h7, 16'h01FF);
        gpr_try(8'hE1, 3'h0, 16'h0108);
        region_try(16'h007F, REGION_IO);
        region_try(16'h0080, REGION_DATA);
        region_try(16'h7FFF, REGION_DATA);
        region_try(16'h8000, REGION_PROG);
        region_try(16'hFFFF, REGION_PROG);
    endtask

    task t_pc();
        wr(REG_PC, 16'hFFFE);
        @(posedge mclk_i);
        pc_step <= 1'b1;
        repeat (2) @(posedge mclk_i);
        pc_step <= 1'b0;
        #1;
        check(pc, 16'h0000);
    endtask

    initial begin
        reset_n = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_we = 1'b0;
        reg_re = 1'b0;
        alu_go = 1'b0;
        alu_op = OP_ADD8;
        pc_step = 1'b0;
        irq_req = 1'b0;
        irq_level = 2'h0;
        gpr_sel = 3'h0;
        mem_addr = 16'h0000;
        repeat (9) @(posedge mclk_i);
        #1;
        t_reset_values();
        @(posedge mclk_i);
        reset_n <= 1'b1;
        t_regs();
        t_alu();
        t_irq();
        t_map();
        t_pc();
        stop_test();
    end
endmodule
